// >>> pkg/rcsr_map.svh
// offsets, field positions, reset values and timing counts of the radio register bank
// assumes inclusion by the top module and the bench
`ifndef RCSR_MAP_SVH
`define RCSR_MAP_SVH
`define RCSR_CMD_READ      3'h0
`define RCSR_CMD_WRITE     3'h1
`define RCSR_OFF_CHANNEL   5'h05
`define RCSR_OFF_SETUP     5'h06
`define RCSR_OFF_STATUS    5'h07
`define RCSR_OFF_OBSERVE   5'h08
`define RCSR_OFF_POWER     5'h09
`define RCSR_OFF_PIPE0     5'h0a
`define RCSR_BIT_CARRIER   7
`define RCSR_BIT_LOW       5
`define RCSR_BIT_LOCK      4
`define RCSR_BIT_HIGH      3
`define RCSR_BIT_RXDR      6
`define RCSR_BIT_TXDS      5
`define RCSR_BIT_MAXRT     4
`define RCSR_CH_RST        7'h02
`define RCSR_PWR_RST       2'h3
`define RCSR_HIGH_RST      1'h1
`define RCSR_PIPE_RST      3'h7
`define RCSR_ADDR0_RST     40'he7e7e7e7e7
`define RCSR_CNT_MAX       4'hf
`define RCSR_CLK_MHZ       10
`define RCSR_RETX_UNIT_US  250
`define RCSR_RETX_UNIT_CYC (`RCSR_RETX_UNIT_US * `RCSR_CLK_MHZ)
`endif

// >>> pkg/rcsr_pkg.sv
// types of the radio register bank
// assumes nothing beyond the map header
package rcsr_pkg;
   typedef enum logic [1:0] {
      RCSR_RATE_1M   = 2'b00,
      RCSR_RATE_2M   = 2'b01,
      RCSR_RATE_250K = 2'b10
   } rcsr_rate_type;
   typedef enum logic [1:0] {
      RCSR_PH_IDLE = 2'b00,
      RCSR_PH_CMD  = 2'b01,
      RCSR_PH_DATA = 2'b10
   } rcsr_phase_type;
endpackage : rcsr_pkg

// >>> rtl/rcsr_top.sv
// radio configuration and status registers behind a serial peripheral port
// assumes serial mode 0 (sample on rising sck), sck well below mclk/4,
// and packet engine events as one-cycle pulses on mclk
//
// Overview of operation
// - retransmit limit zero disables retries; N allows up to N retries
// - channel is bits 6:0, resets to 2, bit 7 reads zero
// - setup bit 7 high turns the continuous carrier on
// - low-rate bit gives 250k and masks high-rate; else high gives 2M, 1M
// - setup bit 4 forces the lock indication, resets to zero
// - power field bits 2:1 pick output level, resets to 11
// - status shifts out on serial output during the command byte
// - status bit 6 set on new received data, write one clears
// - status bit 5 set on packet sent or acknowledged, write one clears
// - status bit 4 set on retries exhausted, blocks traffic until cleared
// - status bits 3:1 give the ready pipe, 111 when empty, reset 111
// - status bit 0 shows the transmit queue is full
// - lost packet count in observe bits 7:4 saturates at 15
// - any channel write clears the lost packet count
// - retry count in observe bits 3:0 clears when a new packet starts
// - power detect bit 0 is read only, bits 7:1 read zero
// - pipe 0 address is 40 bits, resets e7e7e7e7e7, low byte first
// - address width 01/10/11 gives 3/4/5 bytes, low bytes used
// - each unmasked flag pulls the active low interrupt pin
// - retry wait is 250 us times delay field plus one
`timescale 1ns/1ps
`include "rcsr_map.svh"
module rcsr_top #(
   parameter int RETX_UNIT_CYC = `RCSR_RETX_UNIT_CYC
) (
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   input  wire logic                 sck,
   input  wire logic                 csn_n,
   input  wire logic                 mosi,
   output logic                      miso,
   output logic                      miso_oe,
   output logic                      irq_n,
   input  wire logic [3:0]           retransmit_limit,
   input  wire logic [3:0]           retransmit_delay,
   input  wire logic [1:0]           address_width,
   input  wire logic [2:0]           irq_mask,
   input  wire logic                 rx_data_event,
   input  wire logic                 tx_done_event,
   input  wire logic                 ack_fail_event,
   input  wire logic                 tx_packet_start,
   input  wire logic [2:0]           rx_pipe_num,
   input  wire logic                 tx_queue_full,
   input  wire logic                 received_power,
   output logic [6:0]                radio_channel,
   output logic                      continuous_carrier,
   output rcsr_pkg::rcsr_rate_type   data_rate,
   output logic                      pll_lock_force,
   output logic [1:0]                transmit_power,
   output logic                      comm_blocked,
   output logic                      retransmit_start,
   output logic [39:0]               pipe0_receive_address
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [2:0] sck_s1_r, sck_s2_r;
   logic       sck_prev_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sck_s1_r   <= 3'h6;
         sck_s2_r   <= 3'h6;
         sck_prev_r <= 1'h0;
      end else begin
         sck_s1_r   <= {csn_n, mosi, sck};
         sck_s2_r   <= sck_s1_r;
         sck_prev_r <= sck_s2_r[0];
      end
   end
   wire sck_q  = sck_s2_r[0];
   wire mosi_q = sck_s2_r[1];
   wire sel_q  = !sck_s2_r[2];
   wire rise   = sel_q && sck_q && !sck_prev_r;
   wire fall   = sel_q && !sck_q && sck_prev_r;

   // ************************************************************
   // serial framing
   // ************************************************************
   rcsr_pkg::rcsr_phase_type phase_r, phase_nxt;
   logic [2:0] bit_cnt_r;
   logic [7:0] rx_sh_r;
   logic [7:0] cmd_r;
   logic [2:0] data_idx_r;
   logic [7:0] tx_sh_r;
   wire [7:0] rx_byte  = {rx_sh_r[6:0], mosi_q};
   wire       byte_end = rise && (bit_cnt_r == 3'h7);
   wire       data_end = byte_end && (phase_r == rcsr_pkg::RCSR_PH_DATA);
   wire       is_write = (cmd_r[7:5] == `RCSR_CMD_WRITE);
   wire [4:0] reg_addr = cmd_r[4:0];

   always_comb begin
      phase_nxt = phase_r;
      case (phase_r)
         rcsr_pkg::RCSR_PH_IDLE: begin
            if (sel_q) phase_nxt = rcsr_pkg::RCSR_PH_CMD;
         end
         rcsr_pkg::RCSR_PH_CMD: begin
            if (byte_end) phase_nxt = rcsr_pkg::RCSR_PH_DATA;
         end
         rcsr_pkg::RCSR_PH_DATA: phase_nxt = phase_r;
         default: phase_nxt = rcsr_pkg::RCSR_PH_IDLE;
      endcase
      if (!sel_q) phase_nxt = rcsr_pkg::RCSR_PH_IDLE;
   end

   // ************************************************************
   // register state
   // ************************************************************
   logic [6:0]  channel_r;
   logic [7:0]  setup_r;
   logic [2:0]  flags_r;
   logic [2:0]  pipe_r;
   logic        full_r, power_r;
   logic [3:0]  lost_r, retry_r;
   logic [39:0] addr0_r;
   logic [15:0] tmr_r;
   logic        tmr_busy_r;

   // width code 00 is illegal; treated as 5 bytes so no write is lost
   function automatic logic [2:0] addr_bytes(input logic [1:0] aw);
      case (aw)
         2'h1:    addr_bytes = 3'h3;
         2'h2:    addr_bytes = 3'h4;
         default: addr_bytes = 3'h5;
      endcase
   endfunction : addr_bytes

   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction : hit

   wire wr_any   = data_end && is_write;
   wire wr_ch    = wr_any && hit(reg_addr, `RCSR_OFF_CHANNEL) && (data_idx_r == 3'h0);
   wire wr_setup = wr_any && hit(reg_addr, `RCSR_OFF_SETUP) && (data_idx_r == 3'h0);
   wire wr_stat  = wr_any && hit(reg_addr, `RCSR_OFF_STATUS) && (data_idx_r == 3'h0);
   wire wr_addr0 = wr_any && hit(reg_addr, `RCSR_OFF_PIPE0)
                   && (data_idx_r < addr_bytes(address_width));
   wire [2:0] clr_flags = wr_stat ? rx_byte[6:4] : 3'h0;

   // retries: a failure at the limit ends the packet instead of retrying
   wire fail_at_limit = ack_fail_event && (retry_r == retransmit_limit);
   wire fail_retry    = ack_fail_event && !fail_at_limit;
   wire new_packet    = tx_packet_start && !flags_r[0];
   wire [31:0] wait_cyc = (32'(retransmit_delay) + 32'h1) * 32'(RETX_UNIT_CYC);

   wire [7:0] status_byte = {1'b0, flags_r[2:0], pipe_r, full_r};
   wire [7:0] setup_rd    = {setup_r[7], 1'b0, setup_r[5:1], 1'b0};
   wire [7:0] addr_rd     = (data_idx_r < 3'h5) ? addr0_r[{data_idx_r, 3'h0} +: 8] : 8'h00;
   logic [7:0] rd_byte;

   always_comb begin
      logic [7:0] v;
      v = 8'h00;
      case (reg_addr)
         `RCSR_OFF_CHANNEL: v = {1'b0, channel_r};
         `RCSR_OFF_SETUP:   v = setup_rd;
         `RCSR_OFF_STATUS:  v = status_byte;
         `RCSR_OFF_OBSERVE: v = {lost_r, retry_r};
         `RCSR_OFF_POWER:   v = {7'h00, power_r};
         `RCSR_OFF_PIPE0:   v = addr_rd;
         default:           v = 8'h00;
      endcase
      rd_byte = (cmd_r[7:5] == `RCSR_CMD_READ) ? v : 8'h00;
   end

   // ************************************************************
   // serial shift and read path
   // ************************************************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase_r    <= rcsr_pkg::RCSR_PH_IDLE;
         bit_cnt_r  <= 3'h0;
         rx_sh_r    <= 8'h00;
         cmd_r      <= 8'hff;
         data_idx_r <= 3'h0;
         tx_sh_r    <= 8'h00;
         miso       <= 1'b0;
         miso_oe    <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         miso_oe <= sel_q;
         if (!sel_q) begin
            bit_cnt_r  <= 3'h0;
            data_idx_r <= 3'h0;
            tx_sh_r    <= {status_byte[6:0], 1'b0};
            miso       <= status_byte[7];
         end else begin
            if (rise) begin
               bit_cnt_r <= bit_cnt_r + 3'h1;
               rx_sh_r   <= rx_byte;
            end
            if (byte_end && phase_r == rcsr_pkg::RCSR_PH_CMD) cmd_r <= rx_byte;
            if (data_end && data_idx_r != 3'h7) data_idx_r <= data_idx_r + 3'h1;
            if (fall && bit_cnt_r == 3'h0) begin
               miso    <= rd_byte[7];
               tx_sh_r <= {rd_byte[6:0], 1'b0};
            end else if (fall) begin
               miso    <= tx_sh_r[7];
               tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
         end
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   wire [6:0] ch_nxt = wr_ch ? rx_byte[6:0] : channel_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         channel_r <= `RCSR_CH_RST;
         setup_r   <= {4'h0, `RCSR_HIGH_RST, `RCSR_PWR_RST, 1'b0};
         addr0_r   <= `RCSR_ADDR0_RST;
      end else begin
         channel_r <= ch_nxt;
         if (wr_setup) setup_r <= rx_byte;
         if (wr_addr0) addr0_r[{data_idx_r, 3'h0} +: 8] <= rx_byte;
      end
   end

   // ************************************************************
   // status flags, counters, retry timer
   // ************************************************************
   wire [2:0] set_flags = {rx_data_event, tx_done_event, fail_at_limit};
   wire [2:0] flags_nxt = (flags_r & ~clr_flags) | set_flags;           // set beats clear
   wire [3:0] lost_nxt  = wr_ch ? 4'h0
                        : (fail_at_limit && lost_r != `RCSR_CNT_MAX) ? lost_r + 4'h1 : lost_r;
   wire [3:0] retry_nxt = new_packet ? 4'h0
                        : (fail_retry && retry_r != `RCSR_CNT_MAX) ? retry_r + 4'h1 : retry_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         flags_r    <= 3'h0;
         pipe_r     <= `RCSR_PIPE_RST;
         full_r     <= 1'b0;
         power_r    <= 1'b0;
         lost_r     <= 4'h0;
         retry_r    <= 4'h0;
         tmr_r      <= 16'h0;
         tmr_busy_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         pipe_r  <= rx_pipe_num;
         full_r  <= tx_queue_full;
         power_r <= received_power;
         lost_r  <= lost_nxt;
         retry_r <= retry_nxt;
         if (fail_retry) begin
            tmr_r      <= wait_cyc[15:0] - 16'h1;
            tmr_busy_r <= 1'b1;
         end else if (tmr_busy_r && tmr_r != 16'h0) begin
            tmr_r <= tmr_r - 16'h1;
         end else begin
            tmr_busy_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // registered outputs
   // ************************************************************
   wire low_q  = setup_r[`RCSR_BIT_LOW];
   wire high_q = setup_r[`RCSR_BIT_HIGH];
   // high-rate bit is a don't-care once low-rate is set, so 11 maps to 250k
   wire [1:0] rate_sel = low_q ? 2'b10 : {1'b0, high_q};
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq_n                 <= 1'b1;
         radio_channel         <= `RCSR_CH_RST;
         continuous_carrier    <= 1'b0;
         data_rate             <= rcsr_pkg::RCSR_RATE_2M;
         pll_lock_force        <= 1'b0;
         transmit_power        <= `RCSR_PWR_RST;
         comm_blocked          <= 1'b0;
         retransmit_start      <= 1'b0;
         pipe0_receive_address <= `RCSR_ADDR0_RST;
      end else begin
         irq_n                 <= !(|(flags_r & ~irq_mask));
         radio_channel         <= channel_r;
         continuous_carrier    <= setup_r[`RCSR_BIT_CARRIER];
         data_rate             <= rcsr_pkg::rcsr_rate_type'(rate_sel);
         pll_lock_force        <= setup_r[`RCSR_BIT_LOCK];
         transmit_power        <= setup_r[2:1];
         comm_blocked          <= flags_r[0];
         retransmit_start      <= tmr_busy_r && (tmr_r == 16'h0) && !flags_r[0];
         pipe0_receive_address <= addr0_r;
      end
   end

endmodule : rcsr_top

// >>> tb/rcsr_chk.sv
// concurrent checks on the ports of the radio register bank
// assumes a bind onto rcsr_top and the single mclk domain
`timescale 1ns/1ps
module rcsr_chk #(
   parameter int RETX_UNIT_CYC = 4
) (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        csn_n,
   input wire logic        miso_oe,
   input wire logic        irq_n,
   input wire logic [2:0]  irq_mask,
   input wire logic        ack_fail_event,
   input wire logic [3:0]  retransmit_limit,
   input wire logic [3:0]  retransmit_delay,
   input wire logic        comm_blocked,
   input wire logic        retransmit_start,
   input wire logic [6:0]  radio_channel,
   input wire logic [39:0] pipe0_receive_address
);
   logic [15:0] since_fail_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ****************************************
   // retry wait helper and assertions
   // ****************************************
   // saturates so a long idle never wraps into a false short wait
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) since_fail_r <= 16'h0000;
      else if (ack_fail_event) since_fail_r <= 16'h0000;
      else if (since_fail_r != 16'hffff) since_fail_r <= since_fail_r + 16'h0001;
   end
   irq_maxrt_a: assert property (comm_blocked && !$past(irq_mask[0]) |-> !irq_n)
      else $error("retry flag unmasked but interrupt high");
   block_rise_a: assert property ($rose(comm_blocked) |-> $past(ack_fail_event, 2))
      else $error("traffic blocked without a failure");
   limit_zero_a: assert property (ack_fail_event && retransmit_limit == 4'h0 |-> ##2 comm_blocked)
      else $error("failure with zero limit did not block");
   quiet_block_a: assert property (comm_blocked && $past(comm_blocked) |-> !retransmit_start)
      else $error("retransmit while blocked");
   retx_pulse_a: assert property (retransmit_start |=> !retransmit_start)
      else $error("retransmit start longer than one cycle");
   retx_wait_a: assert property (retransmit_start |-> since_fail_r >=
      (16'(retransmit_delay) + 16'h0001) * 16'(RETX_UNIT_CYC))
      else $error("retransmit came before its wait");
   oe_on_a: assert property (!csn_n [*4] |-> miso_oe)
      else $error("serial output not driven in frame");
   oe_off_a: assert property (csn_n [*4] |-> !miso_oe)
      else $error("serial output driven outside frame");
   cfg_quiet_a: assert property (!$stable(radio_channel) ||
      !$stable(pipe0_receive_address) |-> !csn_n)
      else $error("register changed outside a frame");
   cover property (comm_blocked && !irq_n);
   cover property (retransmit_start);
   cover property (!csn_n && miso_oe);
endmodule : rcsr_chk

// >>> tb/rcsr_host.sv
// serial host model for the register bank port
// assumes mode 0 and the bench mclk as its time base
`timescale 1ns/1ps
module rcsr_host (
   input  wire logic mclk,
   input  wire logic miso,
   output logic      sck,
   output logic      csn_n,
   output logic      mosi
);
   initial begin
      sck = 1'b0;
      csn_n = 1'b1;
      mosi = 1'b0;
   end
   // ****************************************
   // one frame: command then n bytes
   // ****************************************
   // 5 mclk per sck phase keeps above the 4 the synchronisers need
   task automatic xfer(input logic [7:0] cmd, input int n, input logic [39:0] wd,
                       output logic [7:0] st, output logic [39:0] rd);
      logic [7:0] b;
      logic [7:0] r;
      rd = 40'h0;
      @(posedge mclk) csn_n <= 1'b0;
      for (int k = 0; k <= n; k++) begin
         b = (k == 0) ? cmd : wd[8*(k-1) +: 8];
         for (int i = 7; i >= 0; i--) begin
            mosi <= b[i];
            repeat (5) @(posedge mclk);
            r[i] = miso;
            sck <= 1'b1;
            repeat (5) @(posedge mclk);
            sck <= 1'b0;
         end
         if (k == 0) st = r;
         else rd[8*(k-1) +: 8] = r;
      end
      repeat (10) @(posedge mclk);
      csn_n <= 1'b1;
      // idle line must not keep the last bit
      mosi <= ~mosi;
      repeat (5) @(posedge mclk);
   endtask : xfer
endmodule : rcsr_host

// >>> tb/testbench.sv
// bench for the radio register bank: serial accesses and packet events
// assumes the host model drives the serial pins
`timescale 1ns/1ps
`include "rcsr_map.svh"
module testbench;
   logic                    mclk, rstn = 1'b0, sck, csn_n, mosi, miso, miso_oe, irq_n;
   logic [3:0]              retransmit_limit = 4'h0, retransmit_delay = 4'h1, ev = 4'h0;
   logic [1:0]              address_width = 2'h3, transmit_power;
   logic [2:0]              irq_mask = 3'h0, rx_pipe_num = 3'h7;
   logic                    tx_queue_full = 1'b0, received_power = 1'b0;
   logic                    continuous_carrier, pll_lock_force, comm_blocked, retransmit_start;
   logic [6:0]              radio_channel;
   logic [39:0]             pipe0_receive_address, d;
   logic [7:0]              st, v, b;
   rcsr_pkg::rcsr_rate_type data_rate;
   int                      fails, comparisons, i, n;
   rcsr_top #(.RETX_UNIT_CYC(4)) rcsr_top_i (
      .mclk, .rstn, .sck, .csn_n, .mosi, .miso, .miso_oe, .irq_n, .retransmit_limit,
      .retransmit_delay, .address_width, .irq_mask, .rx_data_event(ev[0]),
      .tx_done_event(ev[1]), .ack_fail_event(ev[2]), .tx_packet_start(ev[3]),
      .rx_pipe_num, .tx_queue_full, .received_power, .radio_channel, .continuous_carrier,
      .data_rate, .pll_lock_force, .transmit_power, .comm_blocked, .retransmit_start,
      .pipe0_receive_address);
   rcsr_host rcsr_host_i (.mclk, .miso, .sck, .csn_n, .mosi);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ****************************************
   // access, compare and closing tasks
   // ****************************************
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rr(input logic [4:0] a, input int k);
      rcsr_host_i.xfer({`RCSR_CMD_READ, a}, k, 40'h0, st, d);
   endtask : rr
   task automatic ww(input logic [4:0] a, input int k, input logic [39:0] w);
      rcsr_host_i.xfer({`RCSR_CMD_WRITE, a}, k, w, st, d);
   endtask : ww
   task automatic pulse(input int j);
      @(posedge mclk) ev <= 4'h1 << j;
      @(posedge mclk) ev <= 4'h0;
   endtask : pulse
   task automatic conclude;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic retx_wait;
      n = 0;
      while (retransmit_start !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      if (n == 40) begin
         fails++;
         conclude;
      end
   endtask : retx_wait
   initial begin
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      rr(`RCSR_OFF_CHANNEL, 1);
      chk({d[7:0], st}, {8'h02, 8'h0e});
      rr(`RCSR_OFF_SETUP, 1);
      chk({d[7:0], data_rate}, {8'h0e, rcsr_pkg::RCSR_RATE_2M});
      rr(`RCSR_OFF_PIPE0, 5);
      chk(d, 40'he7e7e7e7e7);
      for (i = 0; i < 4; i++) begin
         v = {i[0], 1'b0, i[1], ~i[0], i[0], i[1:0], 1'b0};
         ww(`RCSR_OFF_SETUP, 1, v);
         rr(`RCSR_OFF_SETUP, 1);
         chk(d[7:0], v);
         chk(data_rate, i[1] ? rcsr_pkg::RCSR_RATE_250K :
             (i[0] ? rcsr_pkg::RCSR_RATE_2M : rcsr_pkg::RCSR_RATE_1M));
         chk({continuous_carrier, pll_lock_force, transmit_power}, {i[0], ~i[0], i[1:0]});
      end
      ww(`RCSR_OFF_CHANNEL, 1, 40'hff);
      rr(`RCSR_OFF_CHANNEL, 1);
      chk({d[7:0], radio_channel}, {8'h7f, 7'h7f});
      for (i = 0; i < 3; i++) begin
         b = 8'h40 >> i;
         pulse(i);
         repeat (3) @(posedge mclk);
         chk({irq_n, comm_blocked}, {1'b0, i == 2});
         irq_mask <= 3'h4 >> i;
         repeat (3) @(posedge mclk);
         chk(irq_n, 1'b1);
         irq_mask <= 3'h0;
         ww(`RCSR_OFF_STATUS, 1, 40'h0);
         rr(`RCSR_OFF_STATUS, 1);
         chk(d[7:0], b | 8'h0e);
         ww(`RCSR_OFF_STATUS, 1, b);
         rr(`RCSR_OFF_STATUS, 1);
         chk(d[7:0], 8'h0e);
      end
      retransmit_limit <= 4'h2;
      for (i = 1; i <= 3; i++) begin
         pulse(2);
         if (i < 3) begin
            retx_wait;
            chk(n, 40'd9); // two units of 4 plus the registered pulse
            rr(`RCSR_OFF_OBSERVE, 1);
            chk(d[7:0], 8'h10 | i[7:0]);
         end
      end
      rr(`RCSR_OFF_OBSERVE, 1);
      chk({d[7:0], comm_blocked}, {8'h22, 1'b1});
      pulse(3);
      rr(`RCSR_OFF_OBSERVE, 1);
      chk(d[7:0], 8'h22);
      ww(`RCSR_OFF_STATUS, 1, 40'h10);
      pulse(3);
      rr(`RCSR_OFF_OBSERVE, 1);
      chk(d[7:0], 8'h20);
      retransmit_limit <= 4'h0;
      repeat (16) pulse(2);
      rr(`RCSR_OFF_OBSERVE, 1);
      chk(d[7:0], 8'hf0);
      ww(`RCSR_OFF_CHANNEL, 1, 40'h05);
      rr(`RCSR_OFF_OBSERVE, 1);
      chk(d[7:0], 8'h00);
      ww(`RCSR_OFF_STATUS, 1, 40'h10);
      rx_pipe_num <= 3'h5;
      tx_queue_full <= 1'b1;
      received_power <= 1'b1;
      ww(`RCSR_OFF_STATUS, 1, 40'h0f);
      ww(`RCSR_OFF_POWER, 1, 40'hfe);
      rr(`RCSR_OFF_STATUS, 1);
      chk(d[7:0], 8'h0b);
      rr(`RCSR_OFF_POWER, 1);
      chk(d[7:0], 8'h01);
      address_width <= 2'h1;
      ww(`RCSR_OFF_PIPE0, 5, 40'h5544332211);
      chk(pipe0_receive_address, 40'he7e7332211);
      address_width <= 2'h2;
      ww(`RCSR_OFF_PIPE0, 5, 40'h0102030405);
      chk(pipe0_receive_address, 40'he702030405);
      address_width <= 2'h3;
      ww(`RCSR_OFF_PIPE0, 5, 40'ha5b6c7d8e9);
      rr(`RCSR_OFF_PIPE0, 5);
      chk(d, 40'ha5b6c7d8e9);
      conclude;
   end
endmodule : testbench
bind rcsr_top rcsr_chk #(.RETX_UNIT_CYC(RETX_UNIT_CYC)) rcsr_chk_i (
   .mclk, .rstn, .csn_n, .miso_oe, .irq_n, .irq_mask, .ack_fail_event, .retransmit_limit,
   .retransmit_delay, .comm_blocked, .retransmit_start, .radio_channel,
   .pipe0_receive_address);
